// *** hw/selftest_regs_pkg.sv ***
// constants, register map and state codes for the self-test, timing and audio register slice
package selftest_regs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SELFTEST_CTRL = 8'h24;
  localparam logic [7:0] ADDR_TALLY         = 8'h25;
  localparam logic [7:0] ADDR_HIGH_WIDTH    = 8'h26;
  localparam logic [7:0] ADDR_LOW_WIDTH     = 8'h27;
  localparam logic [7:0] ADDR_DATAPATH2     = 8'h28;

  // values after reset
  localparam logic [7:0] RST_SELFTEST_CTRL  = 8'h00;
  localparam logic [7:0] RST_TALLY          = 8'h00;
  localparam logic [7:0] RST_HIGH_WIDTH     = 8'h83;
  localparam logic [7:0] RST_LOW_WIDTH      = 8'h84;
  localparam logic [7:0] RST_DATAPATH2      = 8'h00;
  localparam logic [7:0] RST_RDATA          = 8'h00;

  // field positions and masks
  localparam int         CTRL_RUN_BIT       = 0;
  localparam int         DP2_BLOCK_FWD_BIT  = 7;
  localparam int         DP2_AUX_AUDIO_BIT  = 3;
  localparam int         DP2_I2S_OFF_BIT    = 2;
  localparam int         DP2_SURROUND_BIT   = 0;
  localparam logic [7:0] CTRL_WMASK         = 8'h01;
  localparam logic [7:0] DP2_WMASK          = 8'h8D;
  localparam logic [7:0] DP2_FWD_MASK       = 8'h0D;
  localparam logic [7:0] TALLY_MAX          = 8'hFF;

  // pulse-width unit
  localparam int         CLK_PERIOD_NS      = 4;
  localparam int         WIDTH_UNIT_NS      = 50;
  localparam int         UNIT_CYC           = (WIDTH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] UNIT_LAST          = 4'(UNIT_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_HIGH  = 4'b0010,
    ST_LOW   = 4'b0100,
    ST_SETUP = 4'b1000
  } scl_state_t;
endpackage

// *** hw/width_timer.sv ***
// counts a programmed number of 50 ns width units and pulses when done
`timescale 1ns/100ps
module width_timer
  import selftest_regs_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  // request
  input  wire logic       start_in,
  input  wire logic [7:0] units_in,
  // answer
  output logic            done_out
);
  typedef struct packed {
    logic       busy;
    logic [3:0] pre;
    logic [7:0] units;
    logic       done;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (start_in) begin
      next_st.busy  = 1'b1;
      next_st.pre   = UNIT_LAST;
      // zero is treated as one unit
      next_st.units = (units_in == 8'h00) ? 8'h01 : units_in;
    end else if (st.busy) begin
      if (st.pre == 4'h0) begin
        next_st.pre = UNIT_LAST;
        if (st.units == 8'h01) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end else begin
          next_st.units = st.units - 8'h01;
        end
      end else begin
        next_st.pre = st.pre - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_out = st.done;
endmodule

// *** hw/selftest_i2c_timing_audio_regs.sv ***
// self-test error tally, local bus clock timing and data-path control registers
//
// Notes on behaviour
// - count forward-channel errors during self-test in an eight-bit read-only tally
// - tally is valid only after the self-test run flag returns to zero
// - tally clears when power-down pin is low and when a new run starts
// - as local master, clock line high for high-width count times 50 ns
// - as local master, clock line low for low-width count times 50 ns
// - as slave, hold clock low for low-width count after data before releasing
// - bit 7 set blocks forward-channel loading of the data-path control register
// - bit 3 routes aux audio word select to gpio1 and data to gpio0
// - bit 2 set asserts only the I2S disable output, not aux audio or surround; cleared after reset
// - bit 0 clear gives two/four channels; set enables surround transport
// - in repeater mode, in-band detected audio mode may override surround bit
// - self-test enable bit starts the run when one; reset value is off
`timescale 1ns/100ps
module selftest_i2c_timing_audio_regs
  import selftest_regs_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  // decoded control bus access
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // power-down pin and self-test errors
  input  wire logic       powerdown_pin_n_in,
  input  wire logic       fwd_error_in,
  output logic            selftest_run_flag_out,
  output logic            tally_valid_out,
  // forward-channel configuration load
  input  wire logic       fwd_load_in,
  input  wire logic [7:0] fwd_data_in,
  // local bus clock line (open drain)
  input  wire logic       master_en_in,
  input  wire logic       slave_setup_in,
  output logic            scl_o_out,
  output logic            scl_oe_out,
  output logic            slave_release_out,
  // audio and gpio
  input  wire logic       repeater_mode_in,
  input  wire logic       inband_valid_in,
  input  wire logic       inband_surround_in,
  input  wire logic       aux_ws_in,
  input  wire logic       aux_data_in,
  input  wire logic [1:0] gpio_data_in,
  output logic      [1:0] gpio_pin_out,
  output logic            aux_audio_en_out,
  output logic            i2s_off_out,
  output logic            surround_out
);
  typedef struct packed {
    scl_state_t state;
    logic [7:0] ctrl;
    logic [7:0] tally;
    logic [7:0] high_w;
    logic [7:0] low_w;
    logic [7:0] dp2;
    logic [7:0] rdata;
    logic       valid;
    logic       scl_oe;
    logic       release_p;
    logic       aux;
    logic       i2s_off;
    logic       surround;
    logic [1:0] gpio;
  } regs_state_t;

  localparam regs_state_t RST_ST = '{
    state: ST_IDLE, ctrl: RST_SELFTEST_CTRL, tally: RST_TALLY, high_w: RST_HIGH_WIDTH,
    low_w: RST_LOW_WIDTH, dp2: RST_DATAPATH2, rdata: RST_RDATA, valid: 1'b1,
    scl_oe: 1'b0, release_p: 1'b0, aux: 1'b0, i2s_off: 1'b0, surround: 1'b0,
    gpio: 2'b00};

  regs_state_t st;
  regs_state_t next_st;
  logic        tmr_start;
  logic [7:0]  tmr_units;
  logic        tmr_done;
  logic        run_start;

  function automatic logic wr_hit(input logic [7:0] addr);
    return reg_wr_in && (reg_addr_in == addr);
  endfunction

  width_timer u_timer (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .start_in  (tmr_start),
    .units_in  (tmr_units),
    .done_out  (tmr_done)
  );

  always_comb begin
    next_st           = st;
    tmr_start         = 1'b0;
    tmr_units         = st.high_w;
    next_st.release_p = 1'b0;

    // self-test enable and error tally
    run_start = wr_hit(ADDR_SELFTEST_CTRL) && reg_wdata_in[CTRL_RUN_BIT]
                && !st.ctrl[CTRL_RUN_BIT];
    if (wr_hit(ADDR_SELFTEST_CTRL)) begin
      next_st.ctrl = reg_wdata_in & CTRL_WMASK;
    end
    if (!powerdown_pin_n_in) begin
      next_st.tally = 8'h00;
    end else begin
      if (run_start) begin
        next_st.tally = 8'h00;
      end
      if (st.ctrl[CTRL_RUN_BIT] && fwd_error_in && next_st.tally != TALLY_MAX) begin
        next_st.tally = next_st.tally + 8'h01;
      end
    end
    next_st.valid = !next_st.ctrl[CTRL_RUN_BIT];

    // width registers
    if (wr_hit(ADDR_HIGH_WIDTH)) begin
      next_st.high_w = reg_wdata_in;
    end
    if (wr_hit(ADDR_LOW_WIDTH)) begin
      next_st.low_w = reg_wdata_in;
    end

    // data-path control: local write wins over a forward-channel load
    if (wr_hit(ADDR_DATAPATH2)) begin
      next_st.dp2 = reg_wdata_in & DP2_WMASK;
    end else if (fwd_load_in && !st.dp2[DP2_BLOCK_FWD_BIT]) begin
      next_st.dp2 = (st.dp2 & ~DP2_FWD_MASK) | (fwd_data_in & DP2_FWD_MASK);
    end

    // audio controls
    next_st.aux     = next_st.dp2[DP2_AUX_AUDIO_BIT];
    next_st.i2s_off = next_st.dp2[DP2_I2S_OFF_BIT];
    if (repeater_mode_in && inband_valid_in) begin
      next_st.surround = inband_surround_in;
    end else begin
      next_st.surround = st.dp2[DP2_SURROUND_BIT];
    end
    if (st.dp2[DP2_AUX_AUDIO_BIT]) begin
      next_st.gpio = {aux_ws_in, aux_data_in};
    end else begin
      next_st.gpio = gpio_data_in;
    end

    // read port
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_SELFTEST_CTRL: next_st.rdata = st.ctrl;
        ADDR_TALLY:         next_st.rdata = st.tally;
        ADDR_HIGH_WIDTH:    next_st.rdata = st.high_w;
        ADDR_LOW_WIDTH:     next_st.rdata = st.low_w;
        ADDR_DATAPATH2:     next_st.rdata = st.dp2;
        default:            next_st.rdata = 8'h00;
      endcase
    end

    // clock line sequencer; a low phase always runs to its end
    case (st.state)
      ST_IDLE: begin
        if (master_en_in) begin
          tmr_start      = 1'b1;
          tmr_units      = st.high_w;
          next_st.scl_oe = 1'b0;
          next_st.state  = ST_HIGH;
        end else if (slave_setup_in) begin
          tmr_start      = 1'b1;
          tmr_units      = st.low_w;
          next_st.scl_oe = 1'b1;
          next_st.state  = ST_SETUP;
        end
      end
      ST_HIGH: begin
        if (tmr_done) begin
          if (master_en_in) begin
            tmr_start      = 1'b1;
            tmr_units      = st.low_w;
            next_st.scl_oe = 1'b1;
            next_st.state  = ST_LOW;
          end else begin
            next_st.state  = ST_IDLE;
          end
        end
      end
      ST_LOW: begin
        if (tmr_done) begin
          tmr_start      = master_en_in;
          tmr_units      = st.high_w;
          next_st.scl_oe = 1'b0;
          next_st.state  = master_en_in ? ST_HIGH : ST_IDLE;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          next_st.scl_oe    = 1'b0;
          next_st.release_p = 1'b1;
          next_st.state     = ST_IDLE;
        end
      end
      default: begin
        next_st.scl_oe = 1'b0;
        next_st.state  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out         = st.rdata;
  assign selftest_run_flag_out = st.ctrl[CTRL_RUN_BIT];
  assign tally_valid_out       = st.valid;
  assign scl_o_out             = 1'b0;
  assign scl_oe_out            = st.scl_oe;
  assign slave_release_out     = st.release_p;
  assign gpio_pin_out          = st.gpio;
  assign aux_audio_en_out      = st.aux;
  assign i2s_off_out           = st.i2s_off;
  assign surround_out          = st.surround;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_drive_low;
    scl_oe_out [*8];
  endsequence
  sequence s_release_high;
    !scl_oe_out [*8];
  endsequence

  chk_tally_count: assert property (
    powerdown_pin_n_in && st.ctrl[0] && fwd_error_in && !reg_wr_in && st.tally != 8'hFF
    |=> st.tally == $past(st.tally) + 8'h01)
    else $error("tally did not count an error");
  chk_tally_saturate: assert property (
    st.tally == 8'hFF && powerdown_pin_n_in && !reg_wr_in |=> st.tally == 8'hFF)
    else $error("tally wrapped past maximum");
  chk_valid_after_run: assert property (
    $fell(selftest_run_flag_out) |-> tally_valid_out ##1 tally_valid_out == !selftest_run_flag_out)
    else $error("tally valid flag wrong");
  chk_powerdown_clear: assert property (
    !powerdown_pin_n_in |=> st.tally == 8'h00)
    else $error("tally not cleared by power-down");
  chk_run_start_clear: assert property (
    run_start && powerdown_pin_n_in |=> st.tally == 8'h00 && selftest_run_flag_out)
    else $error("tally not cleared at run start");
  chk_fwd_block: assert property (
    fwd_load_in && st.dp2[7] && !reg_wr_in |=> st.dp2 == $past(st.dp2))
    else $error("forward load not blocked");
  chk_fwd_load: assert property (
    fwd_load_in && !st.dp2[7] && !reg_wr_in |=> st.dp2[3:0] == ($past(fwd_data_in[3:0]) & 4'hD))
    else $error("forward load not taken");
  chk_reserved_zero: assert property (
    st.dp2[6:4] == 3'b000 && st.dp2[1] == 1'b0)
    else $error("reserved bits set");
  chk_i2s_disable: assert property (
    ##1 i2s_off_out == $past(next_st.dp2[2]))
    else $error("audio disable does not follow bit 2");
  chk_gpio_aux_mux: assert property (
    st.dp2[3] |=> gpio_pin_out == {$past(aux_ws_in), $past(aux_data_in)})
    else $error("aux audio not routed to gpio");
  chk_surround_sel: assert property (
    !(repeater_mode_in && inband_valid_in) |=> surround_out == $past(st.dp2[0]))
    else $error("surround output wrong");
  chk_repeater_override: assert property (
    repeater_mode_in && inband_valid_in |=> surround_out == $past(inband_surround_in))
    else $error("in-band override ignored");
  chk_master_low_hold: assert property (
    $rose(scl_oe_out) && st.state == ST_LOW |-> s_drive_low)
    else $error("master low phase too short");
  chk_master_high_hold: assert property (
    $fell(scl_oe_out) && st.state == ST_HIGH |-> s_release_high)
    else $error("master high phase too short");
  chk_setup_hold: assert property (
    $rose(scl_oe_out) && st.state == ST_SETUP |-> s_drive_low)
    else $error("slave setup released early");
endmodule

// *** sim/host_model.sv ***
// control-bus host issuing single-byte register accesses
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire logic       mclk_in,
  // register bus
  output logic      [7:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end
  // single-cycle register write; data is inverted once the strobe drops
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_out   <= 1'b0;
    @(negedge mclk_in);
    d = reg_rdata_in;
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the self-test, timing and audio register slice
`timescale 1ns/100ps
module tb;
  import selftest_regs_pkg::*;
  logic        mclk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  addr, wdata, rdata, rd, fdata = 8'h00;
  logic        wr, rdq, flag, valid, scl_o, oe, rel, aux_en, i2s_off, sur;
  logic        pd_n = 1'b1, err = 1'b0, fload = 1'b0, men = 1'b0, sset = 1'b0;
  logic        rep = 1'b0, ibv = 1'b0, ibs = 1'b0, ws = 1'b0, dat = 1'b0;
  logic [1:0]  gin = 2'b00, gout;
  logic [31:0] lq = 32'h3008;
  logic [7:0]  dp2_m = 8'h00;
  int          fail_count = 0, n_tests = 0, cyc = 0, tally_m = 0, n, lo;
  bit          run_m = 0;

  host_model i_host (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rdq), .reg_rdata_in(rdata));
  selftest_i2c_timing_audio_regs i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rdq),
    .reg_rdata_out(rdata), .powerdown_pin_n_in(pd_n), .fwd_error_in(err),
    .selftest_run_flag_out(flag), .tally_valid_out(valid), .fwd_load_in(fload),
    .fwd_data_in(fdata), .master_en_in(men), .slave_setup_in(sset), .scl_o_out(scl_o),
    .scl_oe_out(oe), .slave_release_out(rel), .repeater_mode_in(rep),
    .inband_valid_in(ibv), .inband_surround_in(ibs), .aux_ws_in(ws), .aux_data_in(dat),
    .gpio_data_in(gin), .gpio_pin_out(gout), .aux_audio_en_out(aux_en),
    .i2s_off_out(i2s_off), .surround_out(sur));

  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic rnd();
    lq = lfsr(lq);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd_reg(a, rd);
    chk("register", 16'(e), 16'(rd));
  endtask
  task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
    i_host.wr_reg(a, d);
    if (a == ADDR_DATAPATH2) dp2_m = d & 8'h8D;
    if (a == ADDR_SELFTEST_CTRL && d[0] && !run_m) tally_m = 0;
    if (a == ADDR_SELFTEST_CTRL) run_m = d[0];
  endtask
  task automatic fwd(input logic [7:0] d);
    @(posedge mclk_in);
    fdata <= d;
    fload <= 1'b1;
    @(posedge mclk_in);
    fload <= 1'b0;
    fdata <= ~d;
    if (!dp2_m[7]) dp2_m = d & 8'h0D;
  endtask
  // error pulses, random or solid, while the run flag is up
  task automatic errs(input int cnt, input bit solid);
    repeat (cnt) begin
      @(posedge mclk_in);
      rnd();
      err <= solid | lq[0];
      if (solid | lq[0]) tally_m++;
    end
    @(posedge mclk_in);
    err <= 1'b0;
    if (tally_m > 255) tally_m = 255;
  endtask
  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (oe !== lvl && k < 5000) begin
      @(negedge mclk_in);
      k++;
    end
  endtask
  task automatic span(input logic lvl, output int len);
    len = 0;
    while (oe === lvl && len < 5000) begin
      @(negedge mclk_in);
      len++;
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rdchk(ADDR_SELFTEST_CTRL, 8'h00);
    rdchk(ADDR_TALLY, 8'h00);
    rdchk(ADDR_HIGH_WIDTH, 8'h83);
    rdchk(ADDR_LOW_WIDTH, 8'h84);
    rdchk(ADDR_DATAPATH2, 8'h00);
    rdchk(8'h30, 8'h00);
    // audio pins and reserved bits
    wr_m(ADDR_DATAPATH2, 8'hFF);
    rdchk(ADDR_DATAPATH2, dp2_m);
    rnd();
    @(posedge mclk_in);
    ws <= lq[0];
    dat <= lq[1];
    gin <= lq[3:2];
    settle();
    chk("gpio_aux", 16'({ws, dat}), 16'(gout));
    chk("aux_en", 16'(1), 16'(aux_en));
    chk("i2s_off", 16'(1), 16'(i2s_off));
    fwd(8'h00);
    rdchk(ADDR_DATAPATH2, dp2_m);
    wr_m(ADDR_DATAPATH2, 8'h00);
    fwd(8'hFF);
    rdchk(ADDR_DATAPATH2, dp2_m);
    wr_m(ADDR_DATAPATH2, 8'h00);
    settle();
    chk("gpio_norm", 16'(gin), 16'(gout));
    chk("i2s_on", 16'(0), 16'(i2s_off));
    chk("aux_off", 16'(0), 16'(aux_en));
    // self-test counting, clearing, saturation
    wr_m(ADDR_SELFTEST_CTRL, 8'h01);
    @(negedge mclk_in);
    chk("run_flag", 16'(1), 16'(flag));
    chk("valid_run", 16'(0), 16'(valid));
    errs(40, 0);
    wr_m(ADDR_SELFTEST_CTRL, 8'h00);
    @(negedge mclk_in);
    chk("valid_end", 16'(1), 16'(valid));
    wr_m(ADDR_TALLY, 8'hAA);
    rdchk(ADDR_TALLY, 8'(tally_m));
    wr_m(ADDR_SELFTEST_CTRL, 8'h01);
    rdchk(ADDR_TALLY, 8'(tally_m));
    errs(300, 1);
    rdchk(ADDR_TALLY, 8'(tally_m));
    @(posedge mclk_in);
    pd_n <= 1'b0;
    repeat (2) @(posedge mclk_in);
    pd_n <= 1'b1;
    tally_m = 0;
    wr_m(ADDR_SELFTEST_CTRL, 8'h00);
    rdchk(ADDR_TALLY, 8'(tally_m));
    // local master clock widths
    wr_m(ADDR_HIGH_WIDTH, 8'h02);
    wr_m(ADDR_LOW_WIDTH, 8'h03);
    @(posedge mclk_in);
    men <= 1'b1;
    wait_oe(1);
    span(1, n);
    chk("low_width", 16'(3 * UNIT_CYC + 1), 16'(n));
    span(0, n);
    chk("high_width", 16'(2 * UNIT_CYC + 1), 16'(n));
    @(posedge mclk_in);
    men <= 1'b0;
    wait_oe(0);
    repeat (60) @(posedge mclk_in);
    // slave setup stretch
    rnd();
    lo = int'(lq[2:0]) + 1;
    wr_m(ADDR_LOW_WIDTH, 8'(lo));
    @(posedge mclk_in);
    sset <= 1'b1;
    @(posedge mclk_in);
    sset <= 1'b0;
    wait_oe(1);
    span(1, n);
    chk("setup_width", 16'(lo * UNIT_CYC + 1), 16'(n));
    chk("release", 16'(1), 16'(rel));
    chk("scl_drive", 16'(0), 16'(scl_o));
    @(negedge mclk_in);
    chk("release_end", 16'(0), 16'(rel));
    // surround and repeater override
    wr_m(ADDR_DATAPATH2, 8'h01);
    settle();
    chk("surround", 16'(1), 16'(sur));
    @(posedge mclk_in);
    rep <= 1'b1;
    ibv <= 1'b1;
    ibs <= 1'b0;
    settle();
    chk("override", 16'(0), 16'(sur));
    @(posedge mclk_in);
    rep <= 1'b0;
    settle();
    chk("surround_back", 16'(dp2_m[0]), 16'(sur));
    conclude();
  end
endmodule
